// >>> shared/pwr_mode_pkg.sv
// Constants for the halt, standby and wake-up sequencer.
// Assumes a single system clock and an 8-bit plain register port.
package pwr_mode_pkg;

  // Register port widths and word offsets.
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_WAKE = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;

  // Control register field positions.
  localparam int unsigned CTRL_HS_BIT = 0;
  localparam int unsigned CTRL_DIV_LO = 1;
  localparam int unsigned CTRL_IDLE_BIT = 4;
  localparam int unsigned CTRL_KEEP_BIT = 5;

  // Status register field positions.
  localparam int unsigned STAT_PDF_BIT = 0;
  localparam int unsigned STAT_TO_BIT = 1;
  localparam int unsigned STAT_HTO_BIT = 2;
  localparam int unsigned STAT_LTO_BIT = 3;
  localparam int unsigned STAT_MODE_LO = 4;

  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] WAKE_RESET = 8'h00;

  // Lowest divider code that still runs from the high-speed source.
  localparam logic [2:0] DIV_FAST_MIN = 3'h2;

  // Oscillator start-up period in oscillator cycles.
  localparam logic [10:0] SST_CYCLES = 11'h400;

  // Operating modes of the sequencer.
  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_DEEP_SLEEP,
    MODE_SUB_SLEEP,
    MODE_IDLE_STOP,
    MODE_IDLE_FULL,
    MODE_WAKE_WAIT
  } mode_t;

  // Cause of a wake-up, held while the fast oscillator restarts.
  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_EXT_RESET,
    CAUSE_WDT,
    CAUSE_PORT_A,
    CAUSE_IRQ_TAKE,
    CAUSE_IRQ_DEFER
  } cause_t;

  // Owner of the shared start-up timer.
  typedef enum logic [1:0] {
    SST_IDLE,
    SST_FAST,
    SST_SLOW
  } sst_t;

endpackage

// >>> design/halt_power_mode_wakeup_ctrl.sv
// Halt, standby-mode and wake-up sequencer with shared oscillator start-up timer.
// Assumes all inputs synchronous to clk_sys_i, which is never gated itself;
// the clock outputs are enables for the gated domains of the core.
//
// The address map and the plain strobed port were chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module halt_power_mode_wakeup_ctrl
  import pwr_mode_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              reset_n_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              halt_i,
  input  wire logic              clr_wdt_i,
  input  wire logic              wdt_enabled_i,
  input  wire logic              wdt_on_sub_i,
  input  wire logic              lvd_enabled_i,
  input  wire logic              ext_reset_i,
  input  wire logic              wdt_overflow_i,
  input  wire logic [7:0]        port_a_i,
  input  wire logic [7:0]        irq_flag_i,
  input  wire logic [7:0]        irq_enable_i,
  input  wire logic              stack_full_i,
  input  wire logic              fast_osc_tick_i,
  input  wire logic              slow_osc_tick_i,
  output logic                   sysclk_en_o,
  output logic                   timebase_en_o,
  output logic                   subclk_en_o,
  output logic                   wdt_clk_en_o,
  output logic                   wdt_stop_o,
  output logic                   wdt_clear_o,
  output logic                   cpu_hold_o,
  output logic                   io_hold_o,
  output logic                   fast_osc_on_o,
  output logic                   slow_osc_on_o,
  output logic                   sys_undivided_o,
  output logic [2:0]             sys_divider_o,
  output logic                   periph_slow_clk_o,
  output logic                   system_reset_o,
  output logic                   wdt_reset_o,
  output logic                   irq_take_o,
  output logic                   resume_o,
  output logic                   power_down_flag_o,
  output logic                   watchdog_timeout_flag_o,
  output logic                   high_osc_stable_flag_o
);

  // True when the divider code keeps the system on the high-speed source.
  function automatic logic runs_fast(input logic hs, input logic [2:0] div);
    runs_fast = hs | (div >= DIV_FAST_MIN);
  endfunction

  // True in the four standby modes.
  function automatic logic in_standby(input mode_t m);
    in_standby = (m == MODE_DEEP_SLEEP) | (m == MODE_SUB_SLEEP) |
                 (m == MODE_IDLE_STOP) | (m == MODE_IDLE_FULL);
  endfunction

  logic [7:0]  ctrl;
  logic [7:0]  port_a_wake_enable;
  mode_t       mode;
  mode_t       next_mode;
  cause_t      cause;
  cause_t      next_cause;
  sst_t        sst_owner;
  logic [10:0] sst_count;
  logic        high_osc_stable_flag;
  logic        slow_osc_stable;
  logic        power_down_flag;
  logic        watchdog_timeout_flag;
  logic [7:0]  port_a_prev;
  logic [7:0]  irq_armed;
  logic        high_speed_select;
  logic [2:0]  clock_divider_select;
  logic        idle_on_halt_select;
  logic        keep_sysclk_in_idle;
  logic        fast_mode;
  logic        fast_needed;
  logic        slow_needed;
  logic        halt_take;
  logic        sst_tick;
  logic        sst_done;
  logic [7:0]  port_a_fall;
  logic [7:0]  irq_wake;
  logic        wake_ok;

  assign high_speed_select    = ctrl[CTRL_HS_BIT];
  assign clock_divider_select = ctrl[CTRL_DIV_LO +: 3];
  assign idle_on_halt_select  = ctrl[CTRL_IDLE_BIT];
  assign keep_sysclk_in_idle  = ctrl[CTRL_KEEP_BIT];

  // Source selection: leaving slow mode needs only one of the two conditions.
  assign fast_mode = runs_fast(high_speed_select, clock_divider_select);
  assign halt_take = halt_i & (mode == MODE_RUN);

  // Register writes; the control byte steers mode choice and clock source.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl               <= CTRL_RESET;
      port_a_wake_enable <= WAKE_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_CTRL) begin
        ctrl <= reg_wdata_i;
      end
      if (reg_addr_i == ADDR_WAKE) begin
        port_a_wake_enable <= reg_wdata_i;
      end
    end
  end

  // Read data one cycle after the read strobe; unmapped words read zero.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_CTRL: reg_rdata_o <= ctrl;
        ADDR_WAKE: reg_rdata_o <= port_a_wake_enable;
        ADDR_STAT: reg_rdata_o <= {1'b0, mode, slow_osc_stable, high_osc_stable_flag,
                                   watchdog_timeout_flag, power_down_flag};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Port A falling edges; the sampler runs on the free clock, not the gated one.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_a_prev <= 8'hff;
    end else begin
      port_a_prev <= port_a_i;
    end
  end
  assign port_a_fall = port_a_prev & ~port_a_i & port_a_wake_enable;

  // Interrupts whose flag was clear at entry are the only ones that may wake.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_armed <= 8'h00;
    end else if (halt_take) begin
      irq_armed <= ~irq_flag_i;
    end
  end
  assign irq_wake = irq_flag_i & irq_armed;

  // Wake decision with reset first, then watchdog, port A and interrupts.
  always_comb begin
    next_cause = CAUSE_NONE;
    if (ext_reset_i) begin
      next_cause = CAUSE_EXT_RESET;
    end else if (wdt_overflow_i) begin
      next_cause = CAUSE_WDT;
    end else if (|port_a_fall) begin
      next_cause = CAUSE_PORT_A;
    end else if (|(irq_wake & irq_enable_i) && !stack_full_i) begin
      next_cause = CAUSE_IRQ_TAKE;
    end else if (|irq_wake) begin
      next_cause = CAUSE_IRQ_DEFER;
    end
  end

  // The restarted fast oscillator must be stable before code runs again.
  assign wake_ok = !fast_mode | high_osc_stable_flag;

  // Mode choice on halt and the return path through the oscillator wait.
  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_RUN: begin
        if (halt_i) begin
          if (!idle_on_halt_select) begin
            if (wdt_enabled_i | lvd_enabled_i) begin
              next_mode = MODE_SUB_SLEEP;
            end else begin
              next_mode = MODE_DEEP_SLEEP;
            end
          end else if (keep_sysclk_in_idle) begin
            next_mode = MODE_IDLE_FULL;
          end else begin
            next_mode = MODE_IDLE_STOP;
          end
        end
      end
      MODE_DEEP_SLEEP, MODE_SUB_SLEEP, MODE_IDLE_STOP, MODE_IDLE_FULL: begin
        if (next_cause != CAUSE_NONE) begin
          next_mode = MODE_WAKE_WAIT;
        end
      end
      MODE_WAKE_WAIT: begin
        if (wake_ok) begin
          next_mode = MODE_RUN;
        end
      end
      default: next_mode = MODE_RUN;
    endcase
  end

  // Mode and held wake cause.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode  <= MODE_RUN;
      cause <= CAUSE_NONE;
    end else begin
      mode <= next_mode;
      if (in_standby(mode) && next_cause != CAUSE_NONE) begin
        cause <= next_cause;
      end else if (mode == MODE_WAKE_WAIT && wake_ok) begin
        cause <= CAUSE_NONE;
      end
    end
  end

  // One-cycle wake actions when the wait ends.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      system_reset_o <= 1'b0;
      wdt_reset_o    <= 1'b0;
      irq_take_o     <= 1'b0;
      resume_o       <= 1'b0;
    end else begin
      system_reset_o <= 1'b0;
      wdt_reset_o    <= 1'b0;
      irq_take_o     <= 1'b0;
      resume_o       <= 1'b0;
      if (mode == MODE_WAKE_WAIT && wake_ok) begin
        case (cause)
          CAUSE_EXT_RESET: system_reset_o <= 1'b1;
          CAUSE_WDT:       wdt_reset_o    <= 1'b1;
          CAUSE_PORT_A:    resume_o       <= 1'b1;
          CAUSE_IRQ_TAKE:  irq_take_o     <= 1'b1;
          CAUSE_IRQ_DEFER: resume_o       <= 1'b1;
          default:         resume_o       <= 1'b0;
        endcase
      end
    end
  end

  // Power-down flag: set by halt, cleared by clear-watchdog; set wins.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_down_flag <= 1'b0;
    end else if (halt_take) begin
      power_down_flag <= 1'b1;
    end else if (clr_wdt_i) begin
      power_down_flag <= 1'b0;
    end
  end

  // Time-out flag: set on overflow, cleared by halt; set wins.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      watchdog_timeout_flag <= 1'b0;
    end else if (wdt_overflow_i) begin
      watchdog_timeout_flag <= 1'b1;
    end else if (halt_take) begin
      watchdog_timeout_flag <= 1'b0;
    end
  end

  // Oscillator demand: the sub clock stops in deepest sleep and whenever neither watchdog, LVD nor slow mode needs it.
  assign fast_needed = fast_mode &
                       ((mode == MODE_RUN) | (mode == MODE_IDLE_FULL) |
                        (mode == MODE_WAKE_WAIT));
  assign slow_needed = (wdt_enabled_i | lvd_enabled_i | !fast_mode) &
                       (mode != MODE_DEEP_SLEEP);

  // Shared start-up timer; the slow crystal waits while the fast one starts.
  assign sst_tick = (sst_owner == SST_FAST) ? fast_osc_tick_i : slow_osc_tick_i;
  assign sst_done = sst_tick && (sst_count == SST_CYCLES - 11'h001);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sst_owner <= SST_IDLE;
      sst_count <= 11'h000;
    end else begin
      case (sst_owner)
        SST_IDLE: begin
          sst_count <= 11'h000;
          if (fast_needed && !high_osc_stable_flag) begin
            sst_owner <= SST_FAST;
          end else if (slow_needed && !slow_osc_stable) begin
            sst_owner <= SST_SLOW;
          end
        end
        SST_FAST, SST_SLOW: begin
          // A fast restart takes the timer back from the slow crystal.
          if ((sst_owner == SST_FAST && !fast_needed) || sst_done ||
              (sst_owner == SST_SLOW && (!slow_needed || (fast_needed && !high_osc_stable_flag)))) begin
            sst_owner <= SST_IDLE;
            sst_count <= 11'h000;
          end else if (sst_tick) begin
            sst_count <= sst_count + 11'h001;
          end
        end
        default: sst_owner <= SST_IDLE;
      endcase
    end
  end

  // Stable flags drop when their oscillator is switched off.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      high_osc_stable_flag <= 1'b0;
      slow_osc_stable      <= 1'b0;
    end else begin
      if (!fast_needed) begin
        high_osc_stable_flag <= 1'b0;
      end else if (sst_done && sst_owner == SST_FAST) begin
        high_osc_stable_flag <= 1'b1;
      end
      if (!slow_needed) begin
        slow_osc_stable <= 1'b0;
      end else if (sst_done && sst_owner == SST_SLOW) begin
        slow_osc_stable <= 1'b1;
      end
    end
  end

  // Clock gating per mode.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sysclk_en_o   <= 1'b0;
      timebase_en_o <= 1'b0;
      subclk_en_o   <= 1'b0;
      wdt_clk_en_o  <= 1'b0;
      wdt_stop_o    <= 1'b0;
    end else begin
      sysclk_en_o   <= 1'b0;
      timebase_en_o <= 1'b0;
      subclk_en_o   <= 1'b1;
      wdt_clk_en_o  <= wdt_enabled_i & wdt_on_sub_i;
      wdt_stop_o    <= !(wdt_enabled_i & wdt_on_sub_i);
      case (next_mode)
        MODE_RUN: begin
          sysclk_en_o   <= 1'b1;
          timebase_en_o <= 1'b1;
          subclk_en_o   <= slow_needed;
          wdt_clk_en_o  <= wdt_enabled_i;
          wdt_stop_o    <= 1'b0;
        end
        MODE_DEEP_SLEEP: begin
          subclk_en_o   <= 1'b0;
          wdt_clk_en_o  <= 1'b0;
          wdt_stop_o    <= 1'b1;
        end
        MODE_SUB_SLEEP: subclk_en_o <= 1'b1;
        MODE_IDLE_STOP: timebase_en_o <= 1'b1;
        MODE_IDLE_FULL: begin
          sysclk_en_o   <= 1'b1;
          timebase_en_o <= 1'b1;
          wdt_clk_en_o  <= wdt_enabled_i;
          wdt_stop_o    <= !wdt_enabled_i;
        end
        default: begin
          subclk_en_o   <= slow_needed;
          wdt_clk_en_o  <= 1'b0;
          wdt_stop_o    <= 1'b0;
        end
      endcase
    end
  end

  // Halt strobes, holds and source selection.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wdt_clear_o       <= 1'b0;
      cpu_hold_o        <= 1'b0;
      io_hold_o         <= 1'b0;
      sys_undivided_o   <= 1'b0;
      sys_divider_o     <= 3'h0;
      periph_slow_clk_o <= 1'b0;
    end else begin
      wdt_clear_o       <= halt_take;
      cpu_hold_o        <= next_mode != MODE_RUN;
      io_hold_o         <= in_standby(next_mode);
      sys_undivided_o   <= high_speed_select;
      sys_divider_o     <= clock_divider_select;
      periph_slow_clk_o <= !fast_mode;
    end
  end

  assign fast_osc_on_o           = fast_needed;
  assign slow_osc_on_o           = slow_needed;
  assign power_down_flag_o       = power_down_flag;
  assign watchdog_timeout_flag_o = watchdog_timeout_flag;
  assign high_osc_stable_flag_o  = high_osc_stable_flag;

endmodule

`default_nettype wire

// >>> verification/pwr_cpu_model.sv
// Behavioural model of the CPU core and crystals beside the sequencer.
// Assumes a free-running system clock; tasks are called by the bench.
`timescale 1ns/1ps
`default_nettype none
module pwr_cpu_model (
  input  wire logic clk_sys_i,
  input  wire logic high_osc_stable_flag_i,
  output var  logic halt_o,
  output var  logic clr_wdt_o,
  output var  logic fast_osc_tick_o,
  output var  logic slow_osc_tick_o
);
  // Instructions idle low; the fast crystal ticks every cycle to keep start-up short.
  initial begin
    halt_o = 1'b0;
    clr_wdt_o = 1'b0;
    slow_osc_tick_o = 1'b0;
  end
  assign fast_osc_tick_o = 1'b1;

  // The slow crystal ticks every other cycle.
  always @(posedge clk_sys_i) begin
    slow_osc_tick_o <= ~slow_osc_tick_o;
  end

  // Software polls the stable flag before trusting the fast clock, then halts.
  task automatic halt();
    int n;
    n = 0;
    while (high_osc_stable_flag_i !== 1'b1 && n < 2000) begin
      @(posedge clk_sys_i);
      n++;
    end
    @(posedge clk_sys_i);
    halt_o <= 1'b1;
    @(posedge clk_sys_i);
    halt_o <= 1'b0;
  endtask

  // One clear-watchdog instruction.
  task automatic clr_wdt();
    @(posedge clk_sys_i);
    clr_wdt_o <= 1'b1;
    @(posedge clk_sys_i);
    clr_wdt_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verification/pwr_mode_sva.sv
// Port-level assertions for the halt, standby and wake-up sequencer.
// Assumes it is bound to the sequencer top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pwr_mode_sva
  import pwr_mode_pkg::*;
(
  input wire logic              clk_sys_i,
  input wire logic              reset_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              halt_i,
  input wire logic              clr_wdt_i,
  input wire logic              wdt_enabled_i,
  input wire logic              wdt_on_sub_i,
  input wire logic              lvd_enabled_i,
  input wire logic              ext_reset_i,
  input wire logic              wdt_overflow_i,
  input wire logic [7:0]        port_a_i,
  input wire logic              sysclk_en_o,
  input wire logic              timebase_en_o,
  input wire logic              subclk_en_o,
  input wire logic              wdt_clk_en_o,
  input wire logic              wdt_stop_o,
  input wire logic              wdt_clear_o,
  input wire logic              cpu_hold_o,
  input wire logic              io_hold_o,
  input wire logic              periph_slow_clk_o,
  input wire logic              system_reset_o,
  input wire logic              wdt_reset_o,
  input wire logic              irq_take_o,
  input wire logic              resume_o,
  input wire logic              power_down_flag_o,
  input wire logic              watchdog_timeout_flag_o,
  input wire logic              high_osc_stable_flag_o
);
  localparam int WAIT_MAX = 1100;
  logic [7:0]  ctrl_s;
  logic [7:0]  wake_s;
  logic [10:0] wait_cnt;
  logic        act;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  assign act = system_reset_o | wdt_reset_o | irq_take_o | resume_o;

  // Shadow of the control and wake-enable words, so mode choice can be predicted.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_s <= CTRL_RESET;
      wake_s <= WAKE_RESET;
    end else if (reg_wr_i && reg_addr_i == ADDR_CTRL) begin
      ctrl_s <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == ADDR_WAKE) begin
      wake_s <= reg_wdata_i;
    end
  end

  // Counts cycles spent between a wake cause and the release of the core.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_cnt <= '0;
    end else if (!cpu_hold_o || io_hold_o) begin
      wait_cnt <= '0;
    end else if (wait_cnt != 11'h7ff) begin
      wait_cnt <= wait_cnt + 11'h1;
    end
  end

  sequence s_halt;
    halt_i && !cpu_hold_o && !wdt_overflow_i;
  endsequence
  sequence s_sleep;
    s_halt ##0 !ctrl_s[CTRL_IDLE_BIT];
  endsequence
  sequence s_idle;
    s_halt ##0 ctrl_s[CTRL_IDLE_BIT];
  endsequence

  property p_halt_flags;
    s_halt |=> power_down_flag_o && !watchdog_timeout_flag_o && wdt_clear_o && io_hold_o;
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags or holds wrong");
  property p_deep;
    s_sleep ##0 (!wdt_enabled_i && !lvd_enabled_i) |=>
      !sysclk_en_o && !timebase_en_o && !wdt_clk_en_o && wdt_stop_o;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep gating wrong");
  property p_sub;
    s_sleep ##0 (wdt_enabled_i || lvd_enabled_i) |=> !sysclk_en_o && !timebase_en_o &&
      subclk_en_o && (!(wdt_enabled_i && wdt_on_sub_i) || (wdt_clk_en_o && !wdt_stop_o));
  endproperty
  a_sub: assert property (p_sub) else $error("sub sleep gating wrong");
  property p_idle_stop;
    s_idle ##0 !ctrl_s[CTRL_KEEP_BIT] |=> !sysclk_en_o && timebase_en_o && subclk_en_o &&
      (!wdt_enabled_i || wdt_stop_o == !wdt_on_sub_i);
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("idle stop gating wrong");
  property p_idle_full;
    s_idle ##0 ctrl_s[CTRL_KEEP_BIT] |=> sysclk_en_o && timebase_en_o && subclk_en_o &&
      !wdt_stop_o;
  endproperty
  a_idle_full: assert property (p_idle_full) else $error("full idle gating wrong");
  property p_clr_pdf;
    clr_wdt_i && !halt_i |=> !power_down_flag_o;
  endproperty
  a_clr_pdf: assert property (p_clr_pdf) else $error("power-down flag not cleared");
  property p_wdt_to;
    wdt_overflow_i |=> watchdog_timeout_flag_o;
  endproperty
  a_wdt_to: assert property (p_wdt_to) else $error("time-out flag not set");
  property p_port_wake;
    io_hold_o && !ext_reset_i && !wdt_overflow_i &&
      (($past(port_a_i) & ~port_a_i & wake_s) != 8'h00) |=> !io_hold_o && cpu_hold_o;
  endproperty
  a_port_wake: assert property (p_port_wake) else $error("port edge did not wake");
  property p_wait;
    wait_cnt <= WAIT_MAX;
  endproperty
  a_wait: assert property (p_wait) else $error("wake wait too long");
  property p_no_early;
    act |-> high_osc_stable_flag_o || periph_slow_clk_o;
  endproperty
  a_no_early: assert property (p_no_early) else $error("core released before stable");
  property p_action;
    act |-> $onehot({system_reset_o, wdt_reset_o, irq_take_o, resume_o}) &&
      !cpu_hold_o && $past(cpu_hold_o);
  endproperty
  a_action: assert property (p_action) else $error("wake action malformed");
  property p_fast_sel;
    reg_wr_i && reg_addr_i == ADDR_CTRL &&
      (reg_wdata_i[0] || reg_wdata_i[3:1] >= DIV_FAST_MIN) |-> ##[1:3] !periph_slow_clk_o;
  endproperty
  a_fast_sel: assert property (p_fast_sel) else $error("fast source not chosen");
  property p_slow_sel;
    reg_wr_i && reg_addr_i == ADDR_CTRL &&
      !reg_wdata_i[0] && reg_wdata_i[3:1] < DIV_FAST_MIN |-> ##[1:3] periph_slow_clk_o;
  endproperty
  a_slow_sel: assert property (p_slow_sel) else $error("slow source not followed");
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the halt, standby and wake-up sequencer.
// Assumes the CPU model and checker files are compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pwr_mode_pkg::*;
  typedef struct packed {
    logic       idle, keep, wdt, low_voltage_detector;
    logic [2:0] cause;
    mode_t      mode;
    logic [2:0] gates;
    logic [3:0] act;
  } row_t;
  logic       clk_sys_i, reset_n_i, reg_wr_i, reg_rd_i, halt_i, clr_wdt_i;
  logic       wdt_enabled_i, wdt_on_sub_i, lvd_enabled_i, ext_reset_i, wdt_overflow_i;
  logic       stack_full_i, fast_osc_tick_i, slow_osc_tick_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, port_a_i, irq_flag_i, irq_enable_i, s;
  logic       sysclk_en_o, timebase_en_o, subclk_en_o, wdt_clk_en_o, wdt_stop_o, wdt_clear_o;
  logic       cpu_hold_o, io_hold_o, fast_osc_on_o, slow_osc_on_o, sys_undivided_o;
  logic [2:0] sys_divider_o;
  logic       periph_slow_clk_o, system_reset_o, wdt_reset_o, irq_take_o, resume_o;
  logic       power_down_flag_o, watchdog_timeout_flag_o, high_osc_stable_flag_o;
  logic [3:0] a;
  int         miscompares, n_checks;
  row_t       rows [5] = '{
    '{1'b0, 1'b0, 1'b0, 1'b0, 3'h0, MODE_DEEP_SLEEP, 3'h0, 4'h1},
    '{1'b0, 1'b0, 1'b1, 1'b0, 3'h1, MODE_SUB_SLEEP,  3'h1, 4'h2},
    '{1'b1, 1'b0, 1'b0, 1'b1, 3'h2, MODE_IDLE_STOP,  3'h3, 4'h1},
    '{1'b1, 1'b1, 1'b1, 1'b0, 3'h3, MODE_IDLE_FULL,  3'h7, 4'h4},
    '{1'b0, 1'b0, 1'b0, 1'b1, 3'h4, MODE_SUB_SLEEP,  3'h1, 4'h8}};

  halt_power_mode_wakeup_ctrl u_dut (.*);
  pwr_cpu_model u_cpu (.clk_sys_i, .high_osc_stable_flag_i(high_osc_stable_flag_o),
    .halt_o(halt_i), .clr_wdt_o(clr_wdt_i), .fast_osc_tick_o(fast_osc_tick_i),
    .slow_osc_tick_o(slow_osc_tick_i));

  // Free-running 100 MHz clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] ad, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= ad;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  // Presents one wake cause for a single cycle; the interrupt flag stays up.
  task automatic poke(input logic [2:0] c);
    @(posedge clk_sys_i);
    case (c)
      3'h0: port_a_i[0] <= 1'b0;
      3'h1, 3'h2: irq_flag_i[2] <= 1'b1;
      3'h3: wdt_overflow_i <= 1'b1;
      default: ext_reset_i <= 1'b1;
    endcase
    @(posedge clk_sys_i);
    port_a_i <= 8'hff;
    wdt_overflow_i <= 1'b0;
    ext_reset_i <= 1'b0;
  endtask
  // Waits, bounded, for the single wake action pulse.
  task automatic wait_act(output logic [3:0] v);
    int n;
    n = 0;
    v = 4'h0;
    while (v == 4'h0 && n < 2000) begin
      @(posedge clk_sys_i);
      #1;
      v = {system_reset_o, wdt_reset_o, irq_take_o, resume_o};
      n++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Bounds the run; a normal run takes about 6000 cycles.
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    miscompares++;
    stop_test();
  end

  initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, wdt_enabled_i, lvd_enabled_i, ext_reset_i} = 6'h00;
    {wdt_overflow_i, stack_full_i, reg_addr_i, reg_wdata_i, irq_flag_i} = 22'h0;
    wdt_on_sub_i = 1'b1;
    port_a_i = 8'hff;
    irq_enable_i = 8'h04;
    repeat (5) @(posedge clk_sys_i);
    #1;
    check("reset osc", {5'h0, fast_osc_on_o, slow_osc_on_o, cpu_hold_o}, 8'h04);
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rd(ADDR_CTRL, s);
    check("ctrl reset", s, CTRL_RESET);
    rd(ADDR_WAKE, s);
    check("wake reset", s, WAKE_RESET);
    rd(4'hf, s);
    check("unmapped", s, 8'h00);
    wr(ADDR_STAT, 8'hff);
    rd(ADDR_STAT, s);
    check("status reset", {s[6:4], s[1:0]}, 8'h00);
    wr(ADDR_WAKE, 8'h01);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(ADDR_CTRL, {2'h0, rows[i].keep, rows[i].idle, 4'h1});
      wdt_enabled_i <= rows[i].wdt;
      lvd_enabled_i <= rows[i].low_voltage_detector;
      stack_full_i <= (rows[i].cause == 3'h2);
      u_cpu.halt();
      #1;
      check("gates", {sysclk_en_o, timebase_en_o, subclk_en_o}, rows[i].gates);
      check("holds", {wdt_clear_o, io_hold_o, cpu_hold_o}, 8'h07);
      rd(ADDR_STAT, s);
      check("mode", {s[6:4], s[1:0]}, {rows[i].mode, 2'h1});
      poke(rows[i].cause);
      wait_act(a);
      irq_flag_i <= 8'h00;
      check("action", a, rows[i].act);
      check("stable", high_osc_stable_flag_o, 8'h01);
      rd(ADDR_STAT, s);
      check("flags", s[1:0], {rows[i].cause == 3'h3, 1'b1});
      $display("row %0d done", i);
    end
    wdt_enabled_i <= 1'b0;
    lvd_enabled_i <= 1'b0;
    stack_full_i <= 1'b0;
    irq_flag_i <= 8'h04;
    wr(ADDR_CTRL, 8'h01);
    u_cpu.halt();
    port_a_i[1] <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    #1;
    check("no wake", io_hold_o, 8'h01);
    poke(3'h0);
    wait_act(a);
    irq_flag_i <= 8'h00;
    check("port wake", a, 8'h01);
    u_cpu.clr_wdt();
    rd(ADDR_STAT, s);
    check("pdf clear", s[0], 8'h00);
    $display("awkward test done");
    for (int d = 0; d < 8; d++) begin
      wr(ADDR_CTRL, {4'h0, 3'(d), 1'b0});
      repeat (3) @(posedge clk_sys_i);
      #1;
      check("slow", periph_slow_clk_o, 8'(d < 2));
      check("divider", {sys_undivided_o, sys_divider_o}, 8'(d));
    end
    wr(ADDR_CTRL, 8'h01);
    repeat (3) @(posedge clk_sys_i);
    #1;
    check("undivided", sys_undivided_o, 8'h01);
    $display("divider test done");
    stop_test();
  end
endmodule

bind halt_power_mode_wakeup_ctrl pwr_mode_sva u_sva (.*);
`default_nettype wire
